//--- srdp_device.sv
// Device end: serial datagram port with a small register file
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// R1 - One 40-bit frame, address then data, MSB first
// R2 - Host holds select low through whole frame
// R3 - Every register moves as full 32 bits
// R4 - Bit 39 high means write, low read
// R5 - Reply frame shifted out on every transaction
// R6 - After read, reply holds addressed register
// R7 - After write, reply echoes written data
// R8 - Read leaves register untouched except status flags, keeps address
// R9 - Host collects read result one frame later
// R10 - Reply bits 39..32 carry status octet
// R11 - Status captured at frame end, sent next
// R12 - All readable; status clears by writing one
// R13 - Mode 3: sample rising, update after falling
// R14 - Select rise commits last 40 bits; excess daisy-chains
// R15 - Status bit0 reset, bit1 driver error, clear on read
// R16 - Low seven address bits index; reply starts zero
module srdp_device #(
    parameter int NUM_REGS = srdp_pkg::REG_COUNT
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    srdp_link_if.device link,
    input wire logic driver_error_i,
    input wire logic [5:0] status_hi_i,
    input wire logic [6:0] user_addr_i,
    output logic [31:0] user_rdata_o,
    output logic [31:0] wr_data_o,
    output logic [6:0] wr_addr_o,
    output logic wr_stb_o,
    output logic [7:0] global_status_flags_o
);
    ////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [2:0] s1_r, s1_nxt, s2_r, s2_nxt;
    logic sclk_d_r, sclk_d_nxt;
    always_comb begin
        s1_nxt = {link.sclk, link.select_low, link.serial_in};
        s2_nxt = s1_r;
        sclk_d_nxt = s2_r[2];
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s1_r <= 3'h7;
            s2_r <= 3'h7;
            sclk_d_r <= 1'b1;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            sclk_d_r <= sclk_d_nxt;
        end
    end
    logic sclk_s, sel_n_s, sdi_s, rise, fall;
    assign sclk_s = s2_r[2];
    assign sel_n_s = s2_r[1];
    assign sdi_s = s2_r[0];
    assign rise = sclk_s & ~sclk_d_r; // [R13]
    assign fall = ~sclk_s & sclk_d_r; // [R13]
    ////////////////////////////////////////////////////////////////
    // Shifting, commit and reply
    logic [39:0] shift_r, shift_nxt;
    logic sel_d_r, sel_d_nxt;
    logic sdo_r, sdo_nxt;
    logic [31:0] reply_r, reply_nxt;
    logic [7:0] stat_cap_r, stat_cap_nxt;
    logic [7:0] flags_r, flags_nxt;
    logic [31:0] regs_r [NUM_REGS];
    logic [31:0] regs_nxt [NUM_REGS];
    logic wr_stb_nxt;
    logic [31:0] wr_data_nxt;
    logic [6:0] wr_addr_nxt;
    logic start, commit, is_wr;
    logic [6:0] cmd_addr;
    assign start = sel_d_r & ~sel_n_s;
    assign commit = ~sel_d_r & sel_n_s; // [R14]
    assign is_wr = shift_r[srdp_pkg::DIR_POS]; // [R4]
    assign cmd_addr = shift_r[srdp_pkg::ADDR_HI:srdp_pkg::ADDR_LO]; // [R16]
    always_comb begin
        shift_nxt = shift_r;
        sel_d_nxt = sel_n_s;
        sdo_nxt = sdo_r;
        reply_nxt = reply_r;
        stat_cap_nxt = stat_cap_r;
        flags_nxt = flags_r;
        regs_nxt = regs_r;
        wr_stb_nxt = 1'b0;
        wr_data_nxt = wr_data_o;
        wr_addr_nxt = wr_addr_o;
        flags_nxt[srdp_pkg::FLAG_DRVERR_POS] = flags_r[srdp_pkg::FLAG_DRVERR_POS]
            | driver_error_i;
        if (start) begin
            shift_nxt = {stat_cap_r, reply_r}; // [R5] [R10] [R11]
            sdo_nxt = stat_cap_r[srdp_pkg::STATUS_BITS - 1]; // [R1]
        end else if (~sel_n_s && rise) begin
            shift_nxt = {shift_r[38:0], sdi_s}; // [R1] [R13]
        end else if (~sel_n_s && fall) begin
            sdo_nxt = shift_r[srdp_pkg::FRAME_BITS - 1]; // [R14] [R13]
        end
        if (commit) begin
            if (is_wr) begin
                reply_nxt = shift_r[31:0]; // [R7]
                wr_stb_nxt = 1'b1;
                wr_data_nxt = shift_r[31:0]; // [R3]
                wr_addr_nxt = cmd_addr;
                if (cmd_addr == srdp_pkg::GLOBAL_STATUS_FLAGS_ADDR) begin
                    flags_nxt = flags_nxt & ~shift_r[7:0]; // [R12]
                end else begin
                    regs_nxt[cmd_addr] = shift_r[31:0];
                end
            end else begin
                // Data bits ignored on read [R8] [R9]
                if (cmd_addr == srdp_pkg::GLOBAL_STATUS_FLAGS_ADDR) begin
                    reply_nxt = {24'h00_0000, flags_r}; // [R6]
                    flags_nxt = 8'h00; // [R15]
                end else begin
                    reply_nxt = regs_r[cmd_addr]; // [R6] [R12]
                end
            end
            stat_cap_nxt = {status_hi_i, flags_nxt[1:0]}; // [R11] [R15]
        end
        if (driver_error_i) begin
            flags_nxt[srdp_pkg::FLAG_DRVERR_POS] = 1'b1;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            shift_r <= 40'h00_0000_0000;
            sel_d_r <= 1'b1;
            sdo_r <= 1'b1;
            reply_r <= srdp_pkg::ZERO_WORD; // [R16]
            stat_cap_r <= 8'h01;
            flags_r <= 8'h01; // [R15]
            wr_stb_o <= 1'b0;
            wr_data_o <= srdp_pkg::ZERO_WORD;
            wr_addr_o <= 7'h00;
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_r[i] <= srdp_pkg::ZERO_WORD;
            end
        end else begin
            shift_r <= shift_nxt;
            sel_d_r <= sel_d_nxt;
            sdo_r <= sdo_nxt;
            reply_r <= reply_nxt;
            stat_cap_r <= stat_cap_nxt;
            flags_r <= flags_nxt;
            wr_stb_o <= wr_stb_nxt;
            wr_data_o <= wr_data_nxt;
            wr_addr_o <= wr_addr_nxt;
            regs_r <= regs_nxt;
        end
    end
    assign link.serial_out = sdo_r;
    assign user_rdata_o = regs_r[user_addr_i];
    assign global_status_flags_o = flags_r;
endmodule // srdp_device
`default_nettype wire

//--- srdp_pkg.sv
// Shared constants for the serial register datagram port
package srdp_pkg;
    localparam int FRAME_BITS = 40;
    localparam int DATA_BITS = 32;
    localparam int ADDR_BITS = 7;
    localparam int STATUS_BITS = 8;
    localparam int DIR_POS = 39;
    localparam int ADDR_HI = 38;
    localparam int ADDR_LO = 32;
    localparam int CNT_W = 6;
    localparam int REG_COUNT = 128;
    localparam logic [6:0] GLOBAL_STATUS_FLAGS_ADDR = 7'h01;
    localparam int FLAG_RESET_POS = 0;
    localparam int FLAG_DRVERR_POS = 1;
    localparam int LINK_DIV = 4;
    localparam int DIV_W = 4;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

//--- srdp_link_if.sv
// Four-wire serial link between host and device
`timescale 1ns/10ps
`default_nettype none
interface srdp_link_if;
    logic sclk;
    logic select_low;
    logic serial_in;
    logic serial_out;
    modport device (
        input sclk,
        input select_low,
        input serial_in,
        output serial_out
    );
    modport host (
        output sclk,
        output select_low,
        output serial_in,
        input serial_out
    );
endinterface
`default_nettype wire

//--- srdp_host.sv
// Host end: issues one 40-bit frame per request
`timescale 1ns/10ps
`default_nettype none
module srdp_host #(
    parameter int HALF_DIV = srdp_pkg::LINK_DIV
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    srdp_link_if.host link,
    input wire logic req_i,
    input wire logic [39:0] frame_i,
    output logic busy_o,
    output logic done_o,
    output logic [39:0] reply_o
);
    typedef enum logic [1:0] {
        SRDP_IDLE = 2'b00,
        SRDP_LOW = 2'b01,
        SRDP_HIGH = 2'b10,
        SRDP_GAP = 2'b11
    } srdp_state_e;
    srdp_state_e st_r, st_nxt;
    logic [3:0] div_r, div_nxt;
    logic [5:0] bit_r, bit_nxt;
    logic [39:0] tx_r, tx_nxt, rx_r, rx_nxt;
    logic sclk_r, sclk_nxt, sel_r, sel_nxt, done_nxt;
    logic [1:0] sdo_s_r, sdo_s_nxt;
    logic tick;
    assign tick = (div_r == 4'(HALF_DIV - 1));
    always_comb begin
        sdo_s_nxt = {sdo_s_r[0], link.serial_out};
        st_nxt = st_r;
        div_nxt = tick ? 4'h0 : div_r + 4'h1;
        bit_nxt = bit_r;
        tx_nxt = tx_r;
        rx_nxt = rx_r;
        sclk_nxt = sclk_r;
        sel_nxt = sel_r;
        done_nxt = 1'b0;
        unique case (st_r)
            SRDP_IDLE: begin
                div_nxt = 4'h0;
                if (req_i) begin
                    tx_nxt = frame_i; // [R1] [R4]
                    sel_nxt = 1'b0;
                    bit_nxt = 6'h00;
                    st_nxt = SRDP_HIGH;
                end
            end
            SRDP_HIGH: if (tick) begin
                // Sample late in the high phase, after the device's synced update
                if (bit_r != 6'h00) begin
                    rx_nxt = {rx_r[38:0], sdo_s_r[1]}; // [R13]
                end
                if (bit_r == 6'(srdp_pkg::FRAME_BITS)) begin
                    sel_nxt = 1'b1; // [R2]
                    st_nxt = SRDP_GAP;
                end else begin
                    sclk_nxt = 1'b0; // [R13]
                    st_nxt = SRDP_LOW;
                end
            end
            SRDP_LOW: if (tick) begin
                sclk_nxt = 1'b1; // [R13]
                bit_nxt = bit_r + 6'h01;
                st_nxt = SRDP_HIGH;
            end
            SRDP_GAP: if (tick) begin
                done_nxt = 1'b1; // [R9]
                st_nxt = SRDP_IDLE;
            end
        endcase
        // Next input bit goes out with the falling clock, held through the rise
        if (st_r == SRDP_HIGH && tick && bit_r != 6'h00) begin
            tx_nxt = {tx_r[38:0], 1'b0}; // [R13]
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_r <= SRDP_IDLE;
            div_r <= 4'h0;
            bit_r <= 6'h00;
            tx_r <= 40'h00_0000_0000;
            rx_r <= 40'h00_0000_0000;
            sclk_r <= 1'b1;
            sel_r <= 1'b1;
            done_o <= 1'b0;
            sdo_s_r <= 2'h3;
        end else begin
            st_r <= st_nxt;
            div_r <= div_nxt;
            bit_r <= bit_nxt;
            tx_r <= tx_nxt;
            rx_r <= rx_nxt;
            sclk_r <= sclk_nxt;
            sel_r <= sel_nxt;
            done_o <= done_nxt;
            sdo_s_r <= sdo_s_nxt;
        end
    end
    assign link.sclk = sclk_r;
    assign link.select_low = sel_r;
    assign link.serial_in = tx_r[srdp_pkg::FRAME_BITS - 1];
    assign busy_o = (st_r != SRDP_IDLE);
    assign reply_o = rx_r;
endmodule // srdp_host
`default_nettype wire

//--- srdp_link_properties.sv
// Wire checks for the serial datagram link
`timescale 1ns/10ps
`default_nettype none
module srdp_link_properties (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic sclk,
    input wire logic select_low,
    input wire logic serial_in,
    input wire logic serial_out
);
    logic [6:0] rises_r;
    logic [6:0] rises_nxt;
    logic sclk_r;
    logic sclk_nxt;
    ////////////////////////////////////////////////////////////////
    // Count clock rises within a frame
    always_comb begin
        sclk_nxt = sclk;
        rises_nxt = rises_r;
        if (select_low) begin
            rises_nxt = 7'h00;
        end else if (sclk && !sclk_r) begin
            rises_nxt = rises_r + 7'h01;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        rises_r <= rst_i ? 7'h00 : rises_nxt;
        sclk_r <= sclk_nxt;
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_low_half;
        (!sclk)[*4] ##1 sclk;
    endsequence
    sequence s_high_half;
        sclk[*4];
    endsequence
    chk_frame_count: assert property ($rose(select_low) |-> rises_r == 7'h28)
        else $error("frame bit count wrong");
    chk_frame_span: assert property ($fell(select_low) |-> ##[316:340] $rose(select_low))
        else $error("frame length wrong");
    chk_idle_clock: assert property (select_low |-> sclk)
        else $error("clock low outside frame");
    chk_select_steady: assert property (!sclk |-> $stable(select_low))
        else $error("select moved with clock low");
    chk_select_gap: assert property ($rose(select_low) |-> select_low[*4])
        else $error("select gap too short");
    chk_low_half: assert property ($fell(sclk) |-> s_low_half)
        else $error("clock low phase wrong");
    chk_high_half: assert property ($rose(sclk) && !select_low |-> s_high_half)
        else $error("clock high phase wrong");
    chk_in_held: assert property (sclk && $past(sclk) && !select_low && !$past(select_low)
        |-> $stable(serial_in))
        else $error("input moved with clock high");
    chk_out_held: assert property ($rose(sclk) && !select_low |-> ##1 $stable(serial_out)[*3])
        else $error("output moved near rise");
endmodule // srdp_link_properties
`default_nettype wire

//--- spi_register_datagram_port_bench.sv
// Bench joining host and device ends over the link
`timescale 1ns/10ps
`default_nettype none
module spi_register_datagram_port_bench;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic req = 1'b0;
    logic [39:0] frame = 40'h00_0000_0000;
    logic drv_err = 1'b0;
    logic [5:0] st_hi = 6'h00;
    logic [6:0] uaddr = 7'h00;
    logic busy;
    logic done;
    logic [39:0] reply;
    logic [31:0] urd;
    logic [31:0] wdat;
    logic [6:0] wadr;
    logic [7:0] gsf;
    int miscompares = 0;
    int n_tests = 0;
    srdp_link_if link ();
    srdp_device i_srdp_device (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link),
        .driver_error_i(drv_err), .status_hi_i(st_hi), .user_addr_i(uaddr),
        .user_rdata_o(urd), .wr_data_o(wdat), .wr_addr_o(wadr), .wr_stb_o(),
        .global_status_flags_o(gsf));
    srdp_host i_srdp_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link), .req_i(req),
        .frame_i(frame), .busy_o(busy), .done_o(done), .reply_o(reply));
    srdp_link_properties i_props (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sclk(link.sclk),
        .select_low(link.select_low), .serial_in(link.serial_in),
        .serial_out(link.serial_out));
    initial forever #50 ref_clk_i = ~ref_clk_i;
    ////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (miscompares == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [39:0] exp, input logic [39:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic [39:0] f, input logic [39:0] exp);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        req <= 1'b1;
        frame <= f;
        @(posedge ref_clk_i);
        req <= 1'b0;
        while (done !== 1'b1 && n < 400) begin
            @(negedge ref_clk_i);
            n++;
        end
        if (n >= 400) begin
            miscompares++;
            close_out();
        end
        cmp("reply", exp, reply);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_write_echo;
        xfer(40'h05_0000_0000, 40'h01_0000_0000);
        xfer(40'h85_1234_5678, 40'h01_0000_0000);
        xfer(40'h86_9ABC_DEF0, 40'h01_1234_5678);
        cmp("wr", 40'h06_9ABC_DEF0, {1'b0, wadr, wdat});
    endtask
    task automatic t_read_pipe;
        xfer(40'h05_FFFF_FFFF, 40'h01_9ABC_DEF0);
        xfer(40'h06_0000_0000, 40'h01_1234_5678);
        xfer(40'h05_0000_0000, 40'h01_9ABC_DEF0);
        @(posedge ref_clk_i);
        uaddr <= 7'h05;
        @(negedge ref_clk_i);
        cmp("reg", 40'h00_1234_5678, {8'h00, urd});
    endtask
    task automatic t_status;
        xfer(40'h01_0000_0000, 40'h01_1234_5678);
        @(posedge ref_clk_i);
        drv_err <= 1'b1;
        st_hi <= 6'h2A;
        xfer(40'h00_0000_0000, 40'h00_0000_0001);
        @(posedge ref_clk_i);
        drv_err <= 1'b0;
        xfer(40'h81_0000_0002, 40'hAA_0000_0000);
        xfer(40'h00_0000_0000, 40'hA8_0000_0002);
        cmp("flags", 40'h00_0000_0000, {32'h0000_0000, gsf});
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_write_echo();
        t_read_pipe();
        t_status();
        close_out();
    end
    initial begin
        #1_000_000;
        miscompares++;
        close_out();
    end
endmodule // spi_register_datagram_port_bench
`default_nettype wire
